// [rtl/page_branch_pkg.sv]
package page_branch_pkg;

  // microword field positions (lsb of each field)
  localparam int unsigned TYPE_LSB = 0;       // 2-bit type field
  localparam int unsigned SRC_LSB = 2;        // 2-bit source field
  localparam int unsigned GEN_LSB = 4;        // 4-bit general field
  localparam int unsigned IMM_LSB = 8;        // 4-bit immediate_op_field
  localparam int unsigned LIT_LSB = 12;       // 2-bit literal_field
  localparam int unsigned AFLD_LSB = 14;      // 4-bit a field
  localparam int unsigned BFLD_LSB = 18;      // 4-bit b field
  localparam int unsigned MFLD_LSB = 22;      // 1-bit m field
  localparam int unsigned CFLD_LSB = 23;      // 2-bit c field
  localparam int unsigned PAGE_LSB = 25;      // 4-bit target_page_field
  localparam int unsigned RET_LSB = 32;       // 9-bit return address pushed

  // field match codes
  localparam logic [1:0] TYPE_BRANCH = 2'h0;
  localparam logic [1:0] SRC_MEMCTL = 2'h2;
  localparam logic [1:0] SRC_PLAIN = 2'h0;
  localparam logic [3:0] IMM_NOMEM = 4'h3;
  localparam logic [3:0] IMM_STACK = 4'hd;
  localparam logic [1:0] LIT_STACK = 2'h3;
  localparam int unsigned GEN_MEM_BIT = 2;    // x1xx / x0xx selector

  // macroinstruction decode
  localparam logic [7:0] BCS_OPCODE = 8'h8a;
  localparam logic [3:0] BCS_PAGE = 4'h1;     // writable page one
  localparam logic [3:0] ROM_PAGE = 4'h0;     // processor rom page zero
  localparam logic [7:0] BCS_SHORT_MASK = 8'h1f;  // first 32 words

  // reset values
  localparam logic [3:0] SP_RESET = 4'h0;
  localparam logic [3:0] PAGE_RESET = 4'h0;

  // decoded page-branch request
  typedef struct packed {
    logic branch;       // any page branch
    logic push;
    logic pop;
    logic del;
    logic [3:0] page;   // target page
  } branch_req_s;

endpackage : page_branch_pkg

// [rtl/page_branch_microop_decoder.sv]
`timescale 1ns/1ps
module page_branch_microop_decoder #(
  parameter int unsigned STACK_DEPTH = 16,   // subroutine stack levels
  parameter int unsigned RET_W = 9,          // stacked address width
  parameter logic [15:0] PAGE_FITTED = 16'h0003  // pages with a control store
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // microword from the selected store
  input wire logic [63:0] microword_i,
  input wire logic microword_valid_i,   // one cycle per executed microword
  input wire logic rom_exec_i,          // running from processor rom
  // macroinstruction stream
  input wire logic [15:0] macro_word_i,
  input wire logic prelim_decode_i,     // preliminary decode phase
  input wire logic decoder_sel_i,       // instruction decoder selected
  // straps
  input wire logic full_entry_strap_i,  // allow all 256 entries
  input wire logic protect_strap_i,     // fitted: suppress io class
  input wire logic io_class_raw_i,      // io class from processor decode
  // memory port acknowledges, active low
  input wire logic port_a_mem_ack_n_i,
  input wire logic port_b_mem_ack_n_i,
  // page selection and microword buffer
  output logic [3:0] cur_page_o,
  output logic [63:0] microword_buffer_out_o,
  output logic branch_o,                // page branch pulse
  output logic int_enable_o,            // memory-control branch may enable ints
  // stack
  output logic [RET_W-1:0] stack_top_o, // value read by pop
  output logic [3:0] stack_ptr_o,
  // memory control
  output logic high_addr_bit_enable_o,  // stored enable
  output logic addr_bit15_en_o,         // effective bit 15 drive
  output logic lockout_control_a_n_o,
  output logic lockout_control_b_n_o,
  // macroinstruction
  output logic bcs_take_o,              // branch_to_store_macro decoded
  output logic [7:0] bcs_entry_o,
  output logic io_class_signal_o,
  output logic protect_interrupt_o
);

  localparam int unsigned SP_W = $clog2(STACK_DEPTH);

  // timing notes
  // - fields are decoded only in the cycle that carries a valid word
  // - every registered output moves one edge after the deciding word
  // - the bit 15 drive alone follows the rom flag with no delay
  // - the enable itself is kept while running from rom
  // - stack pointer has no guard: push on full and pop on empty wrap
  // - a pop on an empty stack hands back whatever entry zero holds
  // - stack array has no reset, so stale entries stay visible
  // - delete reads and unwinds exactly like a pop
  // - set beats clear when one word asks for both
  // - lockout moves per port, only while that port acks
  // - system logic must keep the two acks from locking together
  // - a microword branch may not carry rom page zero to page one
  // - that move is left to the macro alone
  // - macro entry is cut to 32 words unless the strap is fitted
  // - io class and protect interrupt pulse only with strap removed
  // - buffer follows the page being entered, so an absent page
  //   shows all ones from the first edge of the branch

  // stack storage
  logic [RET_W-1:0] stack_mem [STACK_DEPTH];

  // state registers
  logic [SP_W-1:0] sp_reg; // stack pointer
  logic [SP_W-1:0] sp_next;
  logic [3:0] page_reg; // current page
  logic [3:0] page_next;
  logic hab_reg; // stored bit 15 enable
  logic hab_next;
  logic lock_a_reg; // port a lockout
  logic lock_a_next;
  logic lock_b_reg; // port b lockout
  logic lock_b_next;
  logic branch_reg; // branch pulse
  logic branch_next;
  logic inten_reg; // interrupt enable pulse
  logic inten_next;
  logic bcs_reg; // macro taken pulse
  logic bcs_next;
  logic [7:0] entry_reg; // macro entry address
  logic [7:0] entry_next;
  logic [RET_W-1:0] top_reg; // last popped value
  logic [RET_W-1:0] top_next;
  logic iocl_reg; // io class pulse
  logic iocl_next;
  logic pint_reg; // protect interrupt pulse
  logic pint_next;

  // decode helpers
  page_branch_pkg::branch_req_s req; // decoded request
  logic stack_cls; // stack-class pattern
  logic memctl_br; // branch with memory control
  logic plain_br; // branch without memory control
  logic [3:0] afld; // a field
  logic [3:0] bfld; // b field
  logic [3:0] gfld; // general field
  logic [1:0] cfld; // c field
  logic mfld; // m field
  logic macro_hit; // macro opcode seen

  // field extraction
  function automatic logic [3:0] fld4(input logic [63:0] w, input int unsigned lsb);
    fld4 = w[lsb +: 4];
  endfunction : fld4

  function automatic logic [1:0] fld2(input logic [63:0] w, input int unsigned lsb);
    fld2 = w[lsb +: 2];
  endfunction : fld2

  // microword field decode
  always_comb begin
    // plain fields
    afld = fld4(microword_i, page_branch_pkg::AFLD_LSB);
    bfld = fld4(microword_i, page_branch_pkg::BFLD_LSB);
    gfld = fld4(microword_i, page_branch_pkg::GEN_LSB);
    cfld = fld2(microword_i, page_branch_pkg::CFLD_LSB);
    mfld = microword_i[page_branch_pkg::MFLD_LSB];
    // branch with memory control
    memctl_br = microword_valid_i
      && fld2(microword_i, page_branch_pkg::TYPE_LSB) == page_branch_pkg::TYPE_BRANCH
      && fld2(microword_i, page_branch_pkg::SRC_LSB) == page_branch_pkg::SRC_MEMCTL
      && gfld[page_branch_pkg::GEN_MEM_BIT];
    // branch without memory control
    plain_br = microword_valid_i
      && fld2(microword_i, page_branch_pkg::TYPE_LSB) == page_branch_pkg::TYPE_BRANCH
      && fld2(microword_i, page_branch_pkg::SRC_LSB) == page_branch_pkg::SRC_PLAIN
      && fld4(microword_i, page_branch_pkg::IMM_LSB) == page_branch_pkg::IMM_NOMEM;
    // stack-class pattern
    stack_cls = microword_valid_i
      && fld2(microword_i, page_branch_pkg::TYPE_LSB) == page_branch_pkg::TYPE_BRANCH
      && fld2(microword_i, page_branch_pkg::SRC_LSB) == page_branch_pkg::SRC_PLAIN
      && fld4(microword_i, page_branch_pkg::IMM_LSB) == page_branch_pkg::IMM_STACK
      && fld2(microword_i, page_branch_pkg::LIT_LSB) == page_branch_pkg::LIT_STACK;
    // request bundle
    req.branch = memctl_br || plain_br || stack_cls;
    req.push = stack_cls && afld[1];
    req.pop = stack_cls && afld[2] && !bfld[0];
    req.del = stack_cls && afld[2] && bfld[0];
    req.page = fld4(microword_i, page_branch_pkg::PAGE_LSB);
    // upper opcode, decoder selected, preliminary phase only
    macro_hit = macro_word_i[15:8] == page_branch_pkg::BCS_OPCODE
      && decoder_sel_i && prelim_decode_i;
  end

  // next-state logic
  always_comb begin
    // stored state holds
    sp_next = sp_reg;
    page_next = page_reg;
    hab_next = hab_reg;
    lock_a_next = lock_a_reg;
    lock_b_next = lock_b_reg;
    // pulses default low
    branch_next = 1'b0;
    inten_next = 1'b0;
    bcs_next = 1'b0;
    // held values
    entry_next = entry_reg;
    top_next = top_reg;
    // macro pulses default low
    iocl_next = 1'b0;
    pint_next = 1'b0;
    // page branch selects the target store, never rom page zero to one
    if (req.branch && !(page_reg == page_branch_pkg::ROM_PAGE
        && req.page == page_branch_pkg::BCS_PAGE)) begin
      page_next = req.page;
      branch_next = 1'b1;
      inten_next = memctl_br;
    end
    // stack pointer, wraps freely
    if (req.push) begin
      sp_next = sp_reg + 1'b1;
    end else if (req.pop || req.del) begin
      top_next = stack_mem[sp_reg];
      sp_next = sp_reg - 1'b1;
    end
    // high address bit enable, set wins
    if (stack_cls && mfld) begin
      hab_next = 1'b1;
    end else if (stack_cls && cfld[1]) begin
      hab_next = 1'b0;
    end
    // lockout, gated by port availability; set wins over clear
    if (stack_cls && cfld[0]) begin
      if (!port_a_mem_ack_n_i) lock_a_next = 1'b1;
      if (!port_b_mem_ack_n_i) lock_b_next = 1'b1;
    end else if (stack_cls && afld[0]) begin
      if (!port_a_mem_ack_n_i) lock_a_next = 1'b0;
      if (!port_b_mem_ack_n_i) lock_b_next = 1'b0;
    end
    // branch-to-store macro: sole path rom page zero to page one
    if (macro_hit) begin
      bcs_next = 1'b1;
      page_next = page_branch_pkg::BCS_PAGE;
      entry_next = full_entry_strap_i ? macro_word_i[7:0]
        : (macro_word_i[7:0] & page_branch_pkg::BCS_SHORT_MASK);
      iocl_next = io_class_raw_i && !protect_strap_i;
      pint_next = io_class_raw_i && !protect_strap_i;
    end
  end

  // state registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // idle state
      sp_reg <= '0;
      page_reg <= page_branch_pkg::PAGE_RESET;
      hab_reg <= 1'b0;
      lock_a_reg <= 1'b0;
      lock_b_reg <= 1'b0;
      branch_reg <= 1'b0;
      inten_reg <= 1'b0;
      bcs_reg <= 1'b0;
      entry_reg <= 8'h00;
      top_reg <= '0;
      iocl_reg <= 1'b0;
      pint_reg <= 1'b0;
    end else begin
      // register next values
      sp_reg <= sp_next;
      page_reg <= page_next;
      hab_reg <= hab_next;
      lock_a_reg <= lock_a_next;
      lock_b_reg <= lock_b_next;
      branch_reg <= branch_next;
      inten_reg <= inten_next;
      bcs_reg <= bcs_next;
      entry_reg <= entry_next;
      top_reg <= top_next;
      iocl_reg <= iocl_next;
      pint_reg <= pint_next;
    end
  end

  // stack array write, push lands at pointer plus one
  always_ff @(posedge ref_clk_i) begin
    if (req.push) begin
      stack_mem[sp_next] <= microword_i[page_branch_pkg::RET_LSB +: RET_W];
    end
  end

  // microword buffer: absent page drives all ones
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      microword_buffer_out_o <= {64{1'b1}};
    end else begin
      microword_buffer_out_o <= PAGE_FITTED[page_next] ? microword_i : {64{1'b1}};
    end
  end

  // outputs
  // selected page
  assign cur_page_o = page_reg;
  // branch pulse
  assign branch_o = branch_reg;
  // interrupt enable pulse
  assign int_enable_o = inten_reg;
  // popped value
  assign stack_top_o = top_reg;
  // pointer, widened to the port
  assign stack_ptr_o = 4'(sp_reg);
  // stored enable
  assign high_addr_bit_enable_o = hab_reg;
  // effective bit 15, off while in rom
  assign addr_bit15_en_o = hab_reg && !rom_exec_i;
  // port a lockout, active low
  assign lockout_control_a_n_o = !lock_a_reg;
  // port b lockout, active low
  assign lockout_control_b_n_o = !lock_b_reg;
  // macro taken pulse
  assign bcs_take_o = bcs_reg;
  // macro entry address
  assign bcs_entry_o = entry_reg;
  // io class pulse
  assign io_class_signal_o = iocl_reg;
  // protect interrupt pulse
  assign protect_interrupt_o = pint_reg;

endmodule : page_branch_microop_decoder

// [bench/page_branch_microop_decoder_sva.sv]
`timescale 1ns/1ps
module page_branch_sva #(
  parameter logic [15:0] PAGE_FITTED = 16'h0003
) (
  // clock, reset and inputs
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [63:0] microword_i,
  input wire logic microword_valid_i,
  input wire logic rom_exec_i,
  input wire logic [15:0] macro_word_i,
  input wire logic prelim_decode_i,
  input wire logic decoder_sel_i,
  input wire logic port_a_mem_ack_n_i,
  // outputs watched
  input wire logic [3:0] cur_page_o,
  input wire logic [63:0] microword_buffer_out_o,
  input wire logic [3:0] stack_ptr_o,
  input wire logic high_addr_bit_enable_o,
  input wire logic addr_bit15_en_o,
  input wire logic lockout_control_a_n_o,
  input wire logic bcs_take_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic stk; // stack-class pattern on a valid word
  logic branch_to_store_macro; // macro opcode while decoder selected
  assign stk = microword_valid_i && microword_i[13:8] == 6'h3d && microword_i[3:0] == 4'h0;
  assign branch_to_store_macro = macro_word_i[15:8] == 8'h8a && decoder_sel_i && prelim_decode_i;
  property p_unfit; !PAGE_FITTED[cur_page_o] |-> microword_buffer_out_o == '1; endproperty
  a_unfit: assert property (p_unfit) else $error("unfitted page not all ones");
  property p_push; stk && microword_i[15] && !microword_i[16]
    |=> stack_ptr_o == 4'($past(stack_ptr_o) + 4'h1); endproperty
  a_push: assert property (p_push) else $error("push pointer wrong");
  property p_pop; stk && microword_i[16] && !microword_i[15]
    |=> stack_ptr_o == 4'($past(stack_ptr_o) - 4'h1); endproperty
  a_pop: assert property (p_pop) else $error("pop pointer wrong");
  property p_mset; stk && microword_i[22] |=> high_addr_bit_enable_o; endproperty
  a_mset: assert property (p_mset) else $error("enable not set");
  property p_cclr; stk && microword_i[24] && !microword_i[22] |=> !high_addr_bit_enable_o;
  endproperty
  a_cclr: assert property (p_cclr) else $error("enable not cleared");
  property p_rom; addr_bit15_en_o == (high_addr_bit_enable_o && !rom_exec_i); endproperty
  a_rom: assert property (p_rom) else $error("bit 15 drive wrong");
  property p_lock; stk && microword_i[23] && !port_a_mem_ack_n_i |=> !lockout_control_a_n_o;
  endproperty
  a_lock: assert property (p_lock) else $error("lockout not set");
  property p_busy; port_a_mem_ack_n_i |=> $stable(lockout_control_a_n_o); endproperty
  a_busy: assert property (p_busy) else $error("lockout moved while busy");
  property p_bcs; branch_to_store_macro |=> bcs_take_o && cur_page_o == 4'h1; endproperty
  a_bcs: assert property (p_bcs) else $error("macro not taken");
  property p_nosel; !decoder_sel_i |=> !bcs_take_o; endproperty
  a_nosel: assert property (p_nosel) else $error("macro taken unselected");
  property p_rompg; cur_page_o == 4'h0 && !branch_to_store_macro |=> cur_page_o != 4'h1; endproperty
  a_rompg: assert property (p_rompg) else $error("rom page left to page one");
endmodule : page_branch_sva
bind page_branch_microop_decoder page_branch_sva #(.PAGE_FITTED(PAGE_FITTED)) chk (.*);

// [bench/mem_partner.sv]
`timescale 1ns/1ps
// dual-port memory acks; opposite port refused while locked
module mem_partner (
  input wire logic busy_a_i, // port a busy, ack withheld
  input wire logic lock_a_n_i,
  input wire logic lock_b_n_i,
  output logic port_a_mem_ack_n_o,
  output logic port_b_mem_ack_n_o,
  output logic refused_o // opposite-port access refused
);
  assign port_a_mem_ack_n_o = busy_a_i;
  assign port_b_mem_ack_n_o = 1'b0; // port b always available
  // any lock refuses; both locked serves neither port
  assign refused_o = !lock_a_n_i || !lock_b_n_i;
endmodule : mem_partner

// [bench/test_page_branch_microop_decoder.sv]
`timescale 1ns/1ps
module test_page_branch_microop_decoder;
  logic ref_clk_i, rst_n_i, microword_valid_i, rom_exec_i, prelim_decode_i, decoder_sel_i;
  logic full_entry_strap_i, protect_strap_i, io_class_raw_i, busy_a, refused;
  logic port_a_mem_ack_n_i, port_b_mem_ack_n_i, branch_o, int_enable_o, bcs_take_o;
  logic high_addr_bit_enable_o, addr_bit15_en_o, lockout_control_a_n_o, lockout_control_b_n_o;
  logic io_class_signal_o, protect_interrupt_o;
  logic [63:0] microword_i, microword_buffer_out_o;
  logic [15:0] macro_word_i;
  logic [3:0] cur_page_o, stack_ptr_o;
  logic [8:0] stack_top_o;
  logic [7:0] bcs_entry_o;
  int n_mismatch, checked, cyc;
  page_branch_microop_decoder DUT (.*);
  mem_partner mem (.busy_a_i(busy_a), .lock_a_n_i(lockout_control_a_n_o),
    .lock_b_n_i(lockout_control_b_n_o), .port_a_mem_ack_n_o(port_a_mem_ack_n_i),
    .port_b_mem_ack_n_o(port_b_mem_ack_n_i), .refused_o(refused));
  // clock and hang guard
  initial begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_mismatch = n_mismatch + 1;
      summarize();
    end
  end
  task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checked = checked + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one valid microword, outputs settled at the following negedge
  task mw(input logic [63:0] w);
    @(negedge ref_clk_i);
    microword_i = w;
    microword_valid_i = 1'b1;
    @(negedge ref_clk_i);
    microword_valid_i = 1'b0;
  endtask : mw
  // macroinstruction during preliminary decode
  task mac(input logic [15:0] w, input logic sel);
    @(negedge ref_clk_i);
    macro_word_i = w;
    decoder_sel_i = sel;
    prelim_decode_i = 1'b1;
    @(negedge ref_clk_i);
    prelim_decode_i = 1'b0;
  endtask : mac
  // stack-class word to page one: a, b bit0, m, c, return address
  function logic [63:0] sw(logic [3:0] a, logic b, logic m, logic [1:0] c, logic [8:0] r);
    sw = {23'h0, r, 3'h0, 4'h1, c, m, 3'h0, b, a, 2'h3, 4'hd, 8'h0};
  endfunction : sw
  task summarize;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // main sequence
  initial begin
    {rst_n_i, microword_valid_i, rom_exec_i, prelim_decode_i, decoder_sel_i} = 5'h0;
    {full_entry_strap_i, protect_strap_i, io_class_raw_i, busy_a} = 4'h0;
    {microword_i, macro_word_i, n_mismatch, checked, cyc} = '0;
    repeat (5) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    chk("ptr", 0, stack_ptr_o);
    mw(64'h0a00_0300);
    chk("branch", 1, branch_o);
    chk("int", 0, int_enable_o);
    chk("buf", '1, microword_buffer_out_o);
    mw(64'h0200_0048);
    chk("int", 1, int_enable_o);
    chk("page", 1, cur_page_o);
    mw(sw(4'h2, 0, 0, 0, 9'h0a1));
    chk("ptr", 1, stack_ptr_o);
    mw(sw(4'h4, 0, 0, 0, 0));
    chk("top", 9'h0a1, stack_top_o);
    mw(sw(4'h4, 0, 0, 0, 0));
    chk("ptr", 4'hf, stack_ptr_o);
    mw(sw(4'h2, 0, 0, 0, 9'h155));
    chk("ptr", 0, stack_ptr_o);
    mw(sw(4'h4, 1, 0, 0, 0));
    chk("top", 9'h155, stack_top_o);
    mw(sw(4'h0, 0, 1, 0, 0));
    chk("b15", 1, addr_bit15_en_o);
    rom_exec_i = 1'b1;
    @(negedge ref_clk_i);
    chk("b15", 0, addr_bit15_en_o);
    chk("en", 1, high_addr_bit_enable_o);
    rom_exec_i = 1'b0;
    mw(sw(4'h0, 0, 0, 2'h2, 0));
    chk("en", 0, high_addr_bit_enable_o);
    mw(sw(4'h0, 0, 0, 2'h1, 0));
    chk("refused", 1, refused);
    busy_a = 1'b1;
    mw(sw(4'h1, 0, 0, 0, 0));
    chk("lock_a", 0, lockout_control_a_n_o);
    chk("lock_b", 1, lockout_control_b_n_o);
    busy_a = 1'b0;
    mw(sw(4'h1, 0, 0, 0, 0));
    chk("refused", 0, refused);
    mw(64'h300);
    mw(64'h0200_0048);
    chk("page", 0, cur_page_o);
    mac(16'h8a3c, 1);
    chk("take", 1, bcs_take_o);
    chk("page", 1, cur_page_o);
    chk("entry", 8'h1c, bcs_entry_o);
    full_entry_strap_i = 1'b1;
    io_class_raw_i = 1'b1;
    mac(16'h8a3c, 1);
    chk("entry", 8'h3c, bcs_entry_o);
    chk("pint", 1, protect_interrupt_o);
    chk("io", 1, io_class_signal_o);
    protect_strap_i = 1'b1;
    mac(16'h8a3c, 1);
    chk("io", 0, io_class_signal_o);
    mac(16'h8a3c, 0);
    chk("take", 0, bcs_take_o);
    mac(16'h8b3c, 1);
    chk("take", 0, bcs_take_o);
    summarize();
  end
endmodule : test_page_branch_microop_decoder
